//--- uefcr_defs.vh
// Purpose: Constants for the bridge FIFO and configuration register bank
// Assumes: Byte addresses on a plain register port, 32-bit data
// Notes:   Interrupt registers sit beside the configuration registers
`ifndef UEFCR_DEFS_VH
`define UEFCR_DEFS_VH
`define UEFCR_AW              8
`define UEFCR_DW              32
`define UEFCR_ADDR_RX_CTRL    8'h0c
`define UEFCR_ADDR_TX_CTRL    8'h10
`define UEFCR_ADDR_HARDWARE_CONFIG     8'h14
`define UEFCR_ADDR_IRQ_STS    8'h18
`define UEFCR_ADDR_IRQ_MASK   8'h1c
`define UEFCR_RX_FLUSH_BIT    0
`define UEFCR_TX_FLUSH_BIT    0
`define UEFCR_TX_STOP_BIT     1
`define UEFCR_TX_RUN_BIT      2
`define UEFCR_RST_PROT_BIT    15
`define UEFCR_EMU_SEL_BIT     16
`define UEFCR_DETACH_REQ_BIT  17
`define UEFCR_DETACH_FLG_BIT  18
`define UEFCR_IRQ_HALT_BIT    0
`define UEFCR_IRQ_W           1
`define UEFCR_ZERO32          32'h00000000
`endif

//--- uefcr_regs.v
// Purpose: Receive/transmit control and hardware configuration registers
// Assumes: One clock; power-on reset separate from the device reset
// Notes:   Protected fields survive the device reset but not power-on reset
`timescale 1ns/1ps
`include "uefcr_defs.vh"

// Contract
// - Receive flush pulses receive pointer reset
// - Run bit enables transmitter to drain data
// - Run bit self-clears after halt completes
// - Halt request finishes current frame, stops
// - Halt bit clears only once fully stopped
// - Writes to halt bit ignored while set
// - Halt clears only with datapath empty
// - Transmit flush pulses transmit pointer reset
// - Halt completion pulses sticky interrupt status
// - Detach flag readable, cleared by write
// - Detach request disconnects from the bus
// - Reattach reconnects and sets detach flag
// - Emulation select picks source without EEPROM
// - Emulation select ignored with EEPROM present
// - Emulation select kept through protected reset
// - Protection keeps fields except power-on reset
module uefcr_regs
(
  // Clock and resets
  input  wire                   i_clk,
  input  wire                   i_rst_n,
  input  wire                   i_por_n,
  // Register port
  input  wire [`UEFCR_AW-1:0]   i_addr,
  input  wire [`UEFCR_DW-1:0]   i_wdata,
  input  wire                   i_wr,
  input  wire                   i_rd,
  output reg  [`UEFCR_DW-1:0]   o_rdata,
  // Transmitter handshake
  input  wire                   i_tx_in_frame,
  input  wire                   i_tx_path_empty,
  output reg                    o_tx_enable,
  output reg                    o_tx_stop_req,
  // FIFO pointer resets
  output reg                    o_rx_ptr_reset,
  output reg                    o_tx_ptr_reset,
  // Attach control
  input  wire                   i_phy_link,
  input  wire                   i_gpio_wake,
  output reg                    o_bus_detached,
  // Configuration source
  input  wire                   i_eeprom_present,
  output reg                    o_use_desc_ram,
  // Interrupt
  output reg                    o_irq
);

  reg                     rst_s1;
  reg                     rst_s2;
  reg                     tx_run;
  reg                     tx_stop;
  reg                     detach_flag;
  reg                     detached;
  reg                     rst_prot;
  reg                     emu_sel;
  reg  [`UEFCR_IRQ_W-1:0] irq_sts;
  reg  [`UEFCR_IRQ_W-1:0] irq_mask;
  reg  [`UEFCR_DW-1:0]    next_rdata;
  wire                    tx_halted;
  wire                    halt_done;
  wire                    wr_rx;
  wire                    wr_tx;
  wire                    wr_hw;
  wire                    reattach;
  wire                    prot_rst_n;

  // Reset released through two flops
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  assign wr_rx = i_wr && (i_addr == `UEFCR_ADDR_RX_CTRL);
  assign wr_tx = i_wr && (i_addr == `UEFCR_ADDR_TX_CTRL);
  assign wr_hw = i_wr && (i_addr == `UEFCR_ADDR_HARDWARE_CONFIG);

  // Halted means outside a frame with nothing left in the datapath
  assign tx_halted = !i_tx_in_frame && i_tx_path_empty;
  // The request must have reached the transmitter, else a frame could start
  // in the cycle the halt is declared and leave data behind it
  assign halt_done = tx_stop && o_tx_stop_req && tx_halted;
  assign reattach  = detached && (i_phy_link || i_gpio_wake);

  // Transmit control
  always @(posedge i_clk or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      tx_run  <= 1'b0;
      tx_stop <= 1'b0;
    end
    else
    begin
      if (halt_done)
        tx_run <= 1'b0;
      else if (wr_tx)
        tx_run <= i_wdata[`UEFCR_TX_RUN_BIT];
      if (halt_done)
        tx_stop <= 1'b0;
      else if (wr_tx && !tx_stop)
        tx_stop <= i_wdata[`UEFCR_TX_STOP_BIT];
    end
  end

  // Flush strobes last one cycle and read back as zero
  always @(posedge i_clk or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      o_rx_ptr_reset <= 1'b0;
      o_tx_ptr_reset <= 1'b0;
    end
    else
    begin
      o_rx_ptr_reset <= wr_rx && i_wdata[`UEFCR_RX_FLUSH_BIT];
      o_tx_ptr_reset <= wr_tx && i_wdata[`UEFCR_TX_FLUSH_BIT];
    end
  end

  // Detach and reattach; the request bit is a write strobe only
  always @(posedge i_clk or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      detached    <= 1'b0;
      detach_flag <= 1'b0;
    end
    else
    begin
      if (reattach)
        detached <= 1'b0;
      else if (wr_hw && i_wdata[`UEFCR_DETACH_REQ_BIT])
        detached <= 1'b1;
      // Set wins over the software clear
      if (reattach)
        detach_flag <= 1'b1;
      else if (wr_hw && i_wdata[`UEFCR_DETACH_FLG_BIT])
        detach_flag <= 1'b0;
    end
  end

  // Protection bit itself is cleared by power-on reset or a write, never by device reset
  always @(posedge i_clk or negedge i_por_n)
  begin
    if (!i_por_n)
      rst_prot <= 1'b0;
    else if (!rst_s2 && !rst_prot)
      rst_prot <= 1'b0;
    else if (wr_hw)
      rst_prot <= i_wdata[`UEFCR_RST_PROT_BIT];
  end

  // Protected field: device reset clears it only when unprotected
  assign prot_rst_n = rst_s2 || rst_prot;
  always @(posedge i_clk or negedge i_por_n)
  begin
    if (!i_por_n)
      emu_sel <= 1'b0;
    else if (!prot_rst_n)
      emu_sel <= 1'b0;
    else if (wr_hw)
      emu_sel <= i_wdata[`UEFCR_EMU_SEL_BIT];
  end

  // Interrupt status, write one to clear, set wins
  always @(posedge i_clk or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      irq_sts  <= {`UEFCR_IRQ_W{1'b0}};
      irq_mask <= {`UEFCR_IRQ_W{1'b0}};
    end
    else
    begin
      if (halt_done)
        irq_sts[`UEFCR_IRQ_HALT_BIT] <= 1'b1;
      else if (i_wr && (i_addr == `UEFCR_ADDR_IRQ_STS) && i_wdata[`UEFCR_IRQ_HALT_BIT])
        irq_sts[`UEFCR_IRQ_HALT_BIT] <= 1'b0;
      if (i_wr && (i_addr == `UEFCR_ADDR_IRQ_MASK))
        irq_mask <= i_wdata[`UEFCR_IRQ_W-1:0];
    end
  end

  // Read mux; unmapped and reserved bits read zero
  always @*
  begin
    next_rdata = `UEFCR_ZERO32;
    case (i_addr)
      `UEFCR_ADDR_TX_CTRL:
      begin
        next_rdata[`UEFCR_TX_RUN_BIT]  = tx_run;
        next_rdata[`UEFCR_TX_STOP_BIT] = tx_stop;
      end
      `UEFCR_ADDR_HARDWARE_CONFIG:
      begin
        next_rdata[`UEFCR_DETACH_FLG_BIT] = detach_flag;
        next_rdata[`UEFCR_EMU_SEL_BIT]    = emu_sel;
        next_rdata[`UEFCR_RST_PROT_BIT]   = rst_prot;
      end
      `UEFCR_ADDR_IRQ_STS:
        next_rdata[`UEFCR_IRQ_W-1:0] = irq_sts;
      `UEFCR_ADDR_IRQ_MASK:
        next_rdata[`UEFCR_IRQ_W-1:0] = irq_mask;
      default:
        next_rdata = `UEFCR_ZERO32;
    endcase
  end

  // Registered outputs
  always @(posedge i_clk or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      o_rdata        <= `UEFCR_ZERO32;
      o_tx_enable    <= 1'b0;
      o_tx_stop_req  <= 1'b0;
      o_bus_detached <= 1'b0;
      o_use_desc_ram <= 1'b0;
      o_irq          <= 1'b0;
    end
    else
    begin
      o_rdata        <= i_rd ? next_rdata : `UEFCR_ZERO32;
      o_tx_enable    <= tx_run;
      o_tx_stop_req  <= tx_stop;
      o_bus_detached <= detached;
      o_use_desc_ram <= emu_sel && !i_eeprom_present;
      o_irq          <= |(irq_sts & irq_mask);
    end
  end

endmodule

//--- uefcr_regs_asserts.sv
// Purpose: Port checker for the configuration register bank
// Assumes: One clock; pulse timing allowed a spare cycle
// Notes:   Bound to every instance of the bank
`timescale 1ns/1ps
module uefcr_regs_asserts
(
  input wire        i_clk, i_rst_n, i_por_n, i_wr, i_rd, i_tx_in_frame, i_tx_path_empty,
  input wire        i_phy_link, i_gpio_wake, i_eeprom_present,
  input wire [7:0]  i_addr,
  input wire [31:0] i_wdata, o_rdata,
  input wire        o_tx_enable, o_tx_stop_req, o_rx_ptr_reset, o_tx_ptr_reset,
  input wire        o_bus_detached, o_use_desc_ram, o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire wake = i_phy_link | i_gpio_wake;
  a_rx_flush_pulse: assert property (
    i_wr && i_addr == 8'h0c && i_wdata[0] |-> ##[1:2] o_rx_ptr_reset ##1 !o_rx_ptr_reset)
    else $error("rx pointer reset pulse bad");
  a_tx_flush_pulse: assert property (
    i_wr && i_addr == 8'h10 && i_wdata[0] |-> ##[1:2] o_tx_ptr_reset ##1 !o_tx_ptr_reset)
    else $error("tx pointer reset bad");
  a_run_enables: assert property (
    i_wr && i_addr == 8'h10 && i_wdata[2:1] == 2'b10 && !o_tx_stop_req |-> ##2 o_tx_enable)
    else $error("transmitter not enabled");
  a_run_self_clear: assert property (
    $fell(o_tx_stop_req) |-> !o_tx_enable)
    else $error("run bit kept after halt");
  a_halt_when_empty: assert property (
    $fell(o_tx_stop_req) |-> i_tx_path_empty && $past(i_tx_path_empty))
    else $error("halt cleared with data in path");
  a_rdata_idle_zero: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside read cycle");
  a_eeprom_overrides: assert property (
    i_eeprom_present && $past(i_eeprom_present) |-> !o_use_desc_ram)
    else $error("emulation select used with eeprom");
  a_detach_request: assert property (
    i_wr && i_addr == 8'h14 && i_wdata[17] && !wake |-> ##[1:3] o_bus_detached)
    else $error("detach request ignored");
  a_detach_holds: assert property (
    o_bus_detached && !wake && !$past(wake) |=> o_bus_detached)
    else $error("reattached without cause");
endmodule
bind uefcr_regs uefcr_regs_asserts u_chk (.*);

//--- uefcr_tx_model.sv
// Purpose: Transmit datapath stand-in facing the register bank
// Assumes: i_len sets the frame length, zero means no queued data
// Notes:   Frames repeat with one idle cycle between them while enabled and not halting
`timescale 1ns/1ps
module uefcr_tx_model
(
  input  wire       i_clk, i_rst_n, i_enable, i_stop,
  input  wire [3:0] i_len,
  output wire       o_in_frame, o_path_empty
);
  reg [3:0] cnt;
  assign o_in_frame   = cnt != 4'h0;
  assign o_path_empty = cnt == 4'h0;
  // A frame once started always finishes, as a real datapath would
  always @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      cnt <= 4'h0;
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else if (i_enable && !i_stop)
      cnt <= i_len;
endmodule

//--- usb_ethernet_fifo_config_regs_tb.sv
// Purpose: Scenario bench for the configuration register bank
// Assumes: Transmit datapath modelled by uefcr_tx_model
// Notes:   Only mismatches and the verdict are printed
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR %0t: value mismatch", $time); end end
module usb_ethernet_fifo_config_regs_tb;
  logic        i_clk = 0, i_rst_n = 0, i_por_n = 0, i_wr = 0, i_rd = 0;
  logic        i_phy_link = 0, i_gpio_wake = 0, i_eeprom_present = 0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0]  len = 4'h0;
  wire  [31:0] o_rdata;
  wire         i_tx_in_frame, i_tx_path_empty, o_tx_enable, o_tx_stop_req;
  wire         o_rx_ptr_reset, o_tx_ptr_reset, o_bus_detached, o_use_desc_ram, o_irq;
  int          mismatches = 0, checks = 0, i, j;
  uefcr_regs uut (.*);
  uefcr_tx_model u_tx (.i_clk, .i_rst_n, .i_enable(o_tx_enable), .i_stop(o_tx_stop_req),
    .i_len(len), .o_in_frame(i_tx_in_frame), .o_path_empty(i_tx_path_empty));
  initial forever #10 i_clk = ~i_clk;
  task conclude;
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task rst_dev(input logic por);
    i_rst_n <= 1'b0;
    i_por_n <= !por;
    cyc(4);
    @(posedge i_clk) i_rst_n <= 1'b1;
    i_por_n <= 1'b1;
    cyc(4);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk) i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk) i_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk) i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk) i_rd <= 1'b0;
    #1 `CHK(o_rdata, e)
  endtask
  task t_flush;
    wr(8'h0c, 32'h1);
    #1 `CHK(o_rx_ptr_reset, 1'b1)
    rd(8'h0c, 32'h0);
    `CHK(o_rx_ptr_reset, 1'b0)
    wr(8'h10, 32'h1);
    #1 `CHK(o_tx_ptr_reset, 1'b1)
    rd(8'h10, 32'h0);
    `CHK(o_tx_ptr_reset, 1'b0)
    rd(8'h40, 32'h0);
  endtask
  task t_halt;
    wr(8'h1c, 32'h1);
    wr(8'h10, 32'h4);
    rd(8'h10, 32'h4);
    @(posedge i_clk) len <= 4'h9;
    wr(8'h10, 32'h6);
    wr(8'h10, 32'h4);
    rd(8'h10, 32'h6);
    `CHK(i_tx_in_frame, 1'b1)
    for (i = 0; i < 60 && o_tx_stop_req !== 1'b0; i++) cyc(1);
    if (i == 60)
    begin
      mismatches++;
      conclude;
    end
    cyc(2);
    `CHK(o_tx_enable, 1'b0)
    `CHK(i_tx_in_frame, 1'b0)
    `CHK(i_tx_path_empty, 1'b1)
    `CHK(o_irq, 1'b1)
    rd(8'h18, 32'h1);
    wr(8'h1c, 32'h0);
    cyc(2);
    `CHK(o_irq, 1'b0)
    wr(8'h18, 32'h1);
    wr(8'h1c, 32'h1);
    cyc(2);
    `CHK(o_irq, 1'b0)
  endtask
  // Both reattach sources are tried in turn
  task t_detach;
    for (j = 0; j < 2; j++)
    begin
      wr(8'h14, 32'h20000);
      cyc(4);
      `CHK(o_bus_detached, 1'b1)
      @(posedge i_clk) {i_phy_link, i_gpio_wake} <= (j == 0) ? 2'b10 : 2'b01;
      cyc(3);
      `CHK(o_bus_detached, 1'b0)
      @(posedge i_clk) {i_phy_link, i_gpio_wake} <= 2'b00;
      rd(8'h14, 32'h40000);
      wr(8'h14, 32'h40000);
      rd(8'h14, 32'h0);
    end
  endtask
  task t_emu;
    wr(8'h14, 32'h18000);
    cyc(2);
    `CHK(o_use_desc_ram, 1'b1)
    @(posedge i_clk) i_eeprom_present <= 1'b1;
    cyc(3);
    `CHK(o_use_desc_ram, 1'b0)
    rst_dev(1'b0);
    rd(8'h14, 32'h18000);
    rst_dev(1'b1);
    rd(8'h14, 32'h0);
  endtask
  initial
  begin
    rst_dev(1'b1);
    t_flush;
    t_halt;
    t_detach;
    t_emu;
    conclude;
  end
endmodule
